// ---- hw/ios_defs.vh ----
// constants for the internal oscillator clock source block
// assumes inclusion by bare name from hw/ios_top.v
`ifndef IOS_DEFS_VH
`define IOS_DEFS_VH

// ----------------------------------------------------------------
// system clock and source frequencies
// ----------------------------------------------------------------
`define IOS_SYS_CLK_HZ     20000000
`define IOS_BASE_HZ        500000
`define IOS_HF_HZ          16000000
`define IOS_LF_HZ          31000

// ----------------------------------------------------------------
// select encodings and trim values
// ----------------------------------------------------------------
`define IOS_CFG_INTOSC     3'h4
`define IOS_SCS_INT_BIT    1
`define IOS_IRCF_LF        4'h0
`define IOS_IRCF_MF_LO     4'h1
`define IOS_IRCF_MF_HI     4'h9
`define IOS_TRIM_MAX       6'h1f
`define IOS_TRIM_MIN       6'h20
`define IOS_TRIM_RESET     6'h00

// ----------------------------------------------------------------
// settling windows, in cycles of the base tick
// ----------------------------------------------------------------
`define IOS_STARTUP_TICKS  8'h04
`define IOS_LOCK_TICKS     8'h10
`define IOS_STABLE_TICKS   8'h40

`endif

// ---- hw/ios_top.v ----
// internal oscillator clock sources: base, high, medium and low frequency
// assumes synchronous inputs on i_sys_clk; consumers use the tick outputs
//
// Operation
// - 16 MHz source with postscaled select field
// - calibrated sources enabled by config or select
// - startup delay before high source is used
// - hf ready flag while high source runs
// - hf locked within two percent
// - hf stable within half percent
// - 500 kHz medium source, nine frequencies
// - mf ready flag follows hf ready, after the startup delay
// - both calibrated sources from trimmed base
// - six-bit signed trim, resets to zero
// - trim slews gradually, no completion flag
// - low source ignores the trim
// - uncalibrated 31 kHz low source, no postscaler
// - low source enabled by select or peripheral
// - low source clocks timer, watchdog, monitor
// - lf ready flag while low source runs
// - low source fed straight into the mux
`timescale 1ns/1ps
`include "ios_defs.vh"

module ios_top #(
  parameter ACC_W = 24
) (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_rst_n,
  // control
  input  wire [3:0] i_internal_freq_select,
  input  wire [2:0] i_clock_config_select,
  input  wire [1:0] i_system_clock_source_select,
  input  wire [5:0] i_frequency_trim_register,
  input  wire       i_lf_peripheral_en,
  // clock ticks
  output reg        o_hf_tick,
  output reg        o_mf_tick,
  output reg        o_lf_tick,
  output reg        o_sys_tick,
  output reg        o_power_up_timer_tick,
  output reg        o_watchdog_timer_tick,
  output reg        o_fail_safe_clock_monitor_tick,
  // status
  output reg        o_hf_ready_flag,
  output reg        o_hf_locked_flag,
  output reg        o_hf_stable_flag,
  output reg        o_mf_ready_flag,
  output reg        o_lf_ready_flag
);

  // ----------------------------------------------------------------
  // phase increments; accumulator modulo 2^ACC_W at sys clock
  // ----------------------------------------------------------------
  localparam [47:0] ONE      = 48'h1 << ACC_W;
  localparam [47:0] BASE_INC = (ONE * `IOS_BASE_HZ) / `IOS_SYS_CLK_HZ;
  localparam [47:0] LF_INC   = (ONE * `IOS_LF_HZ) / `IOS_SYS_CLK_HZ;
  localparam [47:0] TRIM_LSB = BASE_INC / 48'd128;
  localparam [31:0] HF_RATIO = `IOS_HF_HZ / `IOS_BASE_HZ;
  localparam [7:0]  HF_MUL   = HF_RATIO[7:0];

  // ----------------------------------------------------------------
  // enables
  // ----------------------------------------------------------------
  wire int_sel  = (i_clock_config_select == `IOS_CFG_INTOSC) ||
                  i_system_clock_source_select[`IOS_SCS_INT_BIT];
  wire ircf_lf  = (i_internal_freq_select == `IOS_IRCF_LF);
  wire cal_en   = int_sel && !ircf_lf;
  wire hf_sel   = i_internal_freq_select > `IOS_IRCF_MF_HI;
  wire lf_en    = (int_sel && ircf_lf) || i_lf_peripheral_en;

  // ----------------------------------------------------------------
  // trim slew: current trim walks one step per base tick
  // ----------------------------------------------------------------
  reg  [5:0]       trim_now;
  reg  [ACC_W-1:0] base_acc;
  reg              base_tick;
  wire signed [6:0] trim_s = {trim_now[5], trim_now};
  wire [47:0] trim_adj = TRIM_LSB * {{41{trim_s[6]}}, trim_s};
  wire [47:0] base_inc = BASE_INC + trim_adj;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trim_now <= `IOS_TRIM_RESET;
    end else if (base_tick && trim_now != i_frequency_trim_register) begin
      // slews silently; software cannot see when it lands
      if ($signed(trim_now) < $signed(i_frequency_trim_register))
        trim_now <= trim_now + 6'h01;
      else
        trim_now <= trim_now - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // base 500 kHz oscillator
  // ----------------------------------------------------------------
  wire [ACC_W:0] base_sum = {1'b0, base_acc} + {1'b0, base_inc[ACC_W-1:0]};
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_acc  <= {ACC_W{1'b0}};
      base_tick <= 1'b0;
    end else if (cal_en) begin
      base_acc  <= base_sum[ACC_W-1:0];
      base_tick <= base_sum[ACC_W];
    end else begin
      base_acc  <= {ACC_W{1'b0}};
      base_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // high source: multiplied base, modelled as at most one tick per sys cycle
  // above 20 MHz is impossible, so 16 MHz rate is gated by accumulator
  // ----------------------------------------------------------------
  reg  [ACC_W-1:0] hf_acc;
  wire [47:0]      hf_inc = base_inc * HF_MUL;
  wire [ACC_W:0]   hf_sum = {1'b0, hf_acc} + {1'b0, hf_inc[ACC_W-1:0]};
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hf_acc <= {ACC_W{1'b0}};
    end else if (cal_en) begin
      hf_acc <= hf_sum[ACC_W-1:0];
    end else begin
      hf_acc <= {ACC_W{1'b0}};
    end
  end
  wire hf_raw = cal_en && hf_sum[ACC_W];

  // ----------------------------------------------------------------
  // settling counter drives ready, locked and stable
  // ----------------------------------------------------------------
  reg [7:0] settle;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle <= 8'h00;
    end else if (!cal_en) begin
      settle <= 8'h00;
    end else if (base_tick && settle != `IOS_STABLE_TICKS) begin
      settle <= settle + 8'h01;
    end
  end
  // high source output held off for the first four base ticks after enable
  wire hf_up = cal_en && (settle >= `IOS_STARTUP_TICKS);

  // ----------------------------------------------------------------
  // postscaler for the select field: divide by 2^(15-ircf) on hf,
  // by 2^(9-ircf) on mf
  // ----------------------------------------------------------------
  reg  [14:0] hf_div;
  reg  [8:0]  mf_div;
  wire [3:0]  hf_sh = 4'hf - i_internal_freq_select;
  wire [3:0]  mf_sh = `IOS_IRCF_MF_HI - i_internal_freq_select;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hf_div <= 15'h0000;
      mf_div <= 9'h000;
    end else if (!cal_en) begin
      // restart with the source so the first base tick gives the first mf edge; hf edges also wait for the startup delay
      hf_div <= 15'h0000;
      mf_div <= 9'h000;
    end else begin
      if (hf_raw) hf_div <= hf_div + 15'h0001;
      if (base_tick) mf_div <= mf_div + 9'h001;
    end
  end
  wire [14:0] hf_mask = (15'h0001 << hf_sh) - 15'h0001;
  wire [8:0]  mf_mask = (9'h001 << mf_sh) - 9'h001;
  wire hf_post = hf_raw && hf_up && ((hf_div & hf_mask) == 15'h0000);
  wire mf_sel  = !hf_sel && !ircf_lf;
  wire mf_post = base_tick && mf_sel &&
                 ((mf_div & mf_mask) == 9'h000);

  // ----------------------------------------------------------------
  // low source: fixed, untrimmed, no postscaler
  // ----------------------------------------------------------------
  reg  [ACC_W-1:0] lf_acc;
  wire [ACC_W:0]   lf_sum = {1'b0, lf_acc} + {1'b0, LF_INC[ACC_W-1:0]};
  reg  [2:0]       lf_cnt;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lf_acc <= {ACC_W{1'b0}};
      lf_cnt <= 3'h0;
    end else if (lf_en) begin
      lf_acc <= lf_sum[ACC_W-1:0];
      if (lf_sum[ACC_W] && lf_cnt != 3'h7) lf_cnt <= lf_cnt + 3'h1;
    end else begin
      lf_acc <= {ACC_W{1'b0}};
      lf_cnt <= 3'h0;
    end
  end
  wire lf_raw = lf_en && lf_sum[ACC_W];

  // ----------------------------------------------------------------
  // registered tick outputs
  // ----------------------------------------------------------------
  // mux: lf goes straight in, no postscaler on that path
  wire next_sys_tick = ircf_lf ? lf_raw : (hf_sel ? hf_post : mf_post);

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hf_tick <= 1'b0;
    end else begin
      o_hf_tick <= hf_post && hf_sel;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mf_tick <= 1'b0;
    end else begin
      o_mf_tick <= mf_post;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lf_tick <= 1'b0;
    end else begin
      o_lf_tick <= lf_raw;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_tick <= 1'b0;
    end else begin
      o_sys_tick <= next_sys_tick;
    end
  end

  // ----------------------------------------------------------------
  // consumer ticks on the untrimmed low source
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_power_up_timer_tick <= 1'b0;
    end else begin
      o_power_up_timer_tick <= lf_raw;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_watchdog_timer_tick <= 1'b0;
    end else begin
      o_watchdog_timer_tick <= lf_raw;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fail_safe_clock_monitor_tick <= 1'b0;
    end else begin
      o_fail_safe_clock_monitor_tick <= lf_raw;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hf_ready_flag <= 1'b0;
    end else begin
      o_hf_ready_flag <= hf_up;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hf_locked_flag <= 1'b0;
    end else begin
      o_hf_locked_flag <= cal_en && settle >= `IOS_LOCK_TICKS;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hf_stable_flag <= 1'b0;
    end else begin
      o_hf_stable_flag <= cal_en && settle >= `IOS_STABLE_TICKS;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mf_ready_flag <= 1'b0;
    end else begin
      o_mf_ready_flag <= hf_up;
    end
  end

  // one lf edge counts as running
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lf_ready_flag <= 1'b0;
    end else begin
      o_lf_ready_flag <= lf_en && (lf_cnt != 3'h0);
    end
  end

endmodule // ios_top

// ---- verif/internal_osc_clock_sources_bench.sv ----
// bench for the oscillator block; counts ticks through the sink model
// assumes a 20 MHz clock and all select inputs as plain levels
`timescale 1ns/1ps
module internal_osc_clock_sources_bench;
  logic i_sys_clk = 0, i_rst_n = 0, clr = 1, per_en = 0;
  logic [3:0] sel = 4'h0;
  logic [2:0] cfg = 3'h0;
  logic [1:0] system_clock_source_select = 2'h0;
  logic [5:0] trim = 6'h00;
  wire hf, mf, lf, sys, pwr, hr, hl, hs, mr, lr;
  logic [4:0][15:0] cnt;
  int err_total = 0, n_tests = 0, i;
  always #25 i_sys_clk = ~i_sys_clk;
  ios_top dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_internal_freq_select(sel),
    .i_clock_config_select(cfg), .i_system_clock_source_select(system_clock_source_select),
    .i_frequency_trim_register(trim), .i_lf_peripheral_en(per_en), .o_hf_tick(hf),
    .o_mf_tick(mf), .o_lf_tick(lf), .o_sys_tick(sys), .o_power_up_timer_tick(pwr),
    .o_watchdog_timer_tick(), .o_fail_safe_clock_monitor_tick(), .o_hf_ready_flag(hr),
    .o_hf_locked_flag(hl), .o_hf_stable_flag(hs), .o_mf_ready_flag(mr), .o_lf_ready_flag(lr));
  ios_tick_sink sink (.i_sys_clk(i_sys_clk), .i_clr(clr), .i_tick({pwr, sys, lf, mf, hf}),
    .o_cnt(cnt));
  task cyc(input int n); repeat (n) @(posedge i_sys_clk); #5; endtask
  task chk(input string what, input logic [15:0] seen, input int lo, input int hi);
    n_tests++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      err_total++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  task win(input int n); clr = 1; cyc(1); clr = 0; cyc(n); endtask
  task t_cal;
    cfg = 3'h4; sel = 4'hf;
    for (i = 0; i < 400 && hr !== 1'b1; i++) cyc(1);
    chk("hf ready", hr, 1, 1);
    chk("mf ready", mr, 1, 1);
    for (i = 0; i < 1500 && hl !== 1'b1; i++) cyc(1);
    chk("hf locked", hl, 1, 1);
    for (i = 0; i < 4000 && hs !== 1'b1; i++) cyc(1);
    chk("hf stable", hs, 1, 1);
    for (int n = 10; n < 16; n++) begin
      sel = n[3:0]; cyc(64); win(256);
      chk("hf ticks", cnt[0], (2048 >> (15 - n)) / 10 - 2, (2048 >> (15 - n)) / 10 + 2);
    end
    for (int n = 5; n < 10; n++) begin
      sel = n[3:0]; cyc(64); win(3200);
      chk("mf ticks", cnt[1], (80 >> (9 - n)) - 1, (80 >> (9 - n)) + 1);
    end
    $display("test calibrated done");
  endtask
  task t_low;
    cfg = 3'h0; system_clock_source_select = 2'h2; sel = 4'h0;
    for (i = 0; i < 1400 && lr !== 1'b1; i++) cyc(1);
    chk("lf ready", lr, 1, 1);
    chk("hf ready off", hr, 0, 0);
    win(3000);
    chk("sys ticks", cnt[3], 4, 5);
    chk("timer ticks", cnt[4], 4, 5);
    system_clock_source_select = 2'h0; per_en = 1; cyc(2);
    chk("lf kept", lr, 1, 1);
    per_en = 0; cyc(2);
    chk("lf off", lr, 0, 0);
    sel = 4'h3; system_clock_source_select = 2'h2; cyc(50);
    chk("hf not yet", hr, 0, 0);
    for (i = 0; i < 400 && hr !== 1'b1; i++) cyc(1);
    chk("hf by source bits", hr, 1, 1);
    $display("test low source done");
  endtask
  task t_trim;
    per_en = 1; sel = 4'h9; trim = 6'h1f; cyc(2500); win(4000);
    chk("mf fast", cnt[1], 110, 140);
    chk("lf at max trim", cnt[2], 5, 7);
    trim = 6'h20; cyc(200); win(400);
    chk("mf slewing", cnt[1], 10, 14);
    cyc(4000); win(4000);
    chk("mf slow", cnt[1], 60, 90);
    chk("lf at min trim", cnt[2], 5, 7);
    chk("timer at min trim", cnt[4], 5, 7);
    $display("test trim done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(2); i_rst_n = 1; cyc(2);
    chk("flags after reset", {hr, hl, hs, mr, lr}, 0, 0);
    t_cal; t_low; t_trim;
    end_of_test;
  end
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    err_total++;
    end_of_test;
  end
endmodule // internal_osc_clock_sources_bench

// ---- verif/ios_tick_sink.sv ----
// clock consumer model: counts each tick it is handed
// assumes ticks are one-cycle pulses on i_sys_clk
`timescale 1ns/1ps
module ios_tick_sink (
  input  wire logic        i_sys_clk,
  input  wire logic        i_clr,
  input  wire logic [4:0]  i_tick,
  output logic [4:0][15:0] o_cnt
);
  always_ff @(posedge i_sys_clk)
    for (int k = 0; k < 5; k++)
      o_cnt[k] <= i_clr ? 16'h0000 : o_cnt[k] + {15'h0000, i_tick[k]};
endmodule // ios_tick_sink

// ---- verif/ios_top_sva.sv ----
// checker for the oscillator block, sees only top-level ports
// assumes ready needs four base ticks, base tick no faster than 32 cycles
`timescale 1ns/1ps
module ios_top_sva (
  input wire logic       i_sys_clk, i_rst_n, i_lf_peripheral_en,
  input wire logic [3:0] i_internal_freq_select,
  input wire logic [2:0] i_clock_config_select,
  input wire logic [1:0] i_system_clock_source_select,
  input wire logic       o_lf_tick, o_power_up_timer_tick, o_watchdog_timer_tick,
  input wire logic       o_fail_safe_clock_monitor_tick, o_hf_ready_flag, o_hf_locked_flag,
  input wire logic       o_hf_stable_flag, o_mf_ready_flag, o_lf_ready_flag
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  wire int_on = i_clock_config_select == 3'h4 || i_system_clock_source_select[1];
  wire cal_en = int_on && i_internal_freq_select != 4'h0;
  wire lf_en  = (int_on && i_internal_freq_select == 4'h0) || i_lf_peripheral_en;
  logic [11:0] on_cnt, lf_gap;
  logic        lf_seen;
  // saturating, so a long enable never wraps back below the settle figures
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_cnt  <= 12'h000;
      lf_gap  <= 12'h000;
      lf_seen <= 1'b0;
    end else begin
      on_cnt  <= cal_en ? on_cnt + {11'h000, on_cnt != 12'hfff} : 12'h000;
      lf_gap  <= (o_lf_tick || !lf_en) ? 12'h000 : lf_gap + 12'h001;
      lf_seen <= lf_en && (lf_seen || o_lf_tick);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_timer_ticks: assert property (o_power_up_timer_tick == o_lf_tick &&
    o_watchdog_timer_tick == o_lf_tick && o_fail_safe_clock_monitor_tick == o_lf_tick)
    else $error("timer tick differs from low tick");
  chk_lock_needs_ready: assert property (o_hf_locked_flag |-> o_hf_ready_flag)
    else $error("locked without ready");
  chk_stable_needs_lock: assert property (o_hf_stable_flag |-> o_hf_locked_flag)
    else $error("stable without locked");
  chk_mf_shares_base: assert property (o_mf_ready_flag == o_hf_ready_flag)
    else $error("medium ready differs from high ready");
  chk_hf_flags_clear: assert property (!cal_en |=> !o_hf_ready_flag && !o_hf_locked_flag)
    else $error("high flags kept while disabled");
  chk_lf_flag_clear: assert property (!lf_en |=> !o_lf_ready_flag)
    else $error("low ready kept while disabled");
  chk_startup_delay: assert property ($rose(o_hf_ready_flag) |-> on_cnt >= 12'h064)
    else $error("high ready too early");
  chk_settle_time: assert property ($rose(o_hf_stable_flag) |-> on_cnt >= 12'h5dc)
    else $error("high stable too early");
  chk_lf_pulse: assert property (o_lf_tick |=> !o_lf_tick)
    else $error("low tick longer than one cycle");
  chk_lf_period: assert property (o_lf_tick && lf_seen |-> lf_gap inside {[600:700]})
    else $error("low tick spacing off");
  cover property ($rose(o_hf_stable_flag));
  cover property ($rose(o_lf_ready_flag));
  cover property (o_lf_tick && lf_seen);
endmodule // ios_top_sva

bind ios_top ios_top_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_lf_peripheral_en(i_lf_peripheral_en), .i_internal_freq_select(i_internal_freq_select),
  .i_clock_config_select(i_clock_config_select),
  .i_system_clock_source_select(i_system_clock_source_select), .o_lf_tick(o_lf_tick),
  .o_power_up_timer_tick(o_power_up_timer_tick), .o_watchdog_timer_tick(o_watchdog_timer_tick),
  .o_fail_safe_clock_monitor_tick(o_fail_safe_clock_monitor_tick),
  .o_hf_ready_flag(o_hf_ready_flag), .o_hf_locked_flag(o_hf_locked_flag),
  .o_hf_stable_flag(o_hf_stable_flag), .o_mf_ready_flag(o_mf_ready_flag),
  .o_lf_ready_flag(o_lf_ready_flag));
